// >>> hdl/epwmo_pkg.sv
// constants and register map of the enhanced pwm output stage
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`default_nettype none

package epwmo_pkg;

  // apb map
  localparam int ADDR_W = 8;
  localparam logic [7:0] UNIT_CTRL_OFS = 8'h00;
  localparam logic [7:0] AS_CTRL_OFS = 8'h04;
  localparam logic [7:0] DB_CTRL_OFS = 8'h08;
  localparam logic [7:0] STEER_CTRL_OFS = 8'h0C;
  localparam logic [7:0] PIN_STAT_OFS = 8'h10;

  // field positions
  localparam int CFG_LSB = 6;
  localparam int STAT_BIT = 7;
  localparam int SRC_LSB = 4;
  localparam int SDA_LSB = 2;
  localparam int SDB_LSB = 0;
  localparam int RESTART_BIT = 7;
  localparam int SYNC_BIT = 4;

  // reset values
  localparam logic [7:0] UNIT_CTRL_RST = 8'h00;
  localparam logic [7:0] AS_CTRL_RST = 8'h00;
  localparam logic [7:0] DB_CTRL_RST = 8'h00;
  localparam logic [1:0] STEER_RST = 2'h1;

  // timing: one instruction cycle is four oscillator clocks
  localparam int TOSC_PER_TCY = 4;
  localparam int DIV_W = $clog2(TOSC_PER_TCY);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TOSC_PER_TCY - 1);
  localparam int DB_W = 7;

  // mode and configuration codes
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_HALF = 2'h2;

  typedef enum logic [2:0] {
    EPWMO_SRC_NONE = 3'h0,
    EPWMO_SRC_FAULT = 3'h1,
    EPWMO_SRC_CMP = 3'h2,
    EPWMO_SRC_BOTH = 3'h3
  } epwmo_src_t;

  // shutdown pin states; 2'h3 also gives high impedance
  localparam logic [1:0] SD_DRIVE0 = 2'h0;
  localparam logic [1:0] SD_DRIVE1 = 2'h1;
  localparam logic [1:0] SD_HIZ = 2'h2;

endpackage

`default_nettype wire

// >>> hdl/epwmo_deadband.sv
// dead-band delay for one pwm output
`default_nettype none

module epwmo_deadband
  import epwmo_pkg::*;
#(
  parameter int CNT_W = DB_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic bypass_i,
  input wire logic req_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic act_o
);

  typedef struct packed {
    logic req;
    logic act;
    logic [CNT_W-1:0] cnt;
  } epwmo_db_st_t;

  epwmo_db_st_t st_q;
  epwmo_db_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.req = req_i;
    if (!req_i) begin
      st_d.act = 1'b0;
    end else if (!st_q.req) begin
      st_d.cnt = count_i;
      st_d.act = bypass_i || (count_i == '0);
    end else if (!st_q.act) begin
      // request ending before expiry leaves output inactive
      if (st_q.cnt == '0) begin
        st_d.act = 1'b1;
      end else if (tick_i) begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign act_o = st_q.act;

endmodule

`default_nettype wire

// >>> hdl/epwmo_pin_drive.sv
// polarity and shutdown forcing for one pwm pin
`default_nettype none

module epwmo_pin_drive
  import epwmo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic act_i,
  input wire logic low_i,
  input wire logic shut_i,
  input wire logic [1:0] state_i,
  output logic pin_o,
  output logic oe_n_o
);

  typedef struct packed {
    logic en;
    logic lvl;
  } epwmo_pin_st_t;

  epwmo_pin_st_t st_q;
  epwmo_pin_st_t st_d;
  logic forced;

  always_comb begin
    st_d.en = en_i;
    st_d.lvl = act_i ^ low_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // shutdown bypasses the flops so it acts without a clock edge
  assign forced = shut_i && st_q.en;
  assign pin_o = forced ? (state_i == SD_DRIVE1) : st_q.lvl;
  assign oe_n_o = !st_q.en || (forced && state_i[1]);

endmodule

`default_nettype wire

// >>> hdl/epwmo_top.sv
// enhanced pwm output stage: apb registers, shutdown, steering, pins
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`default_nettype none

module epwmo_top
  import epwmo_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic PWM_RAW_I,
  input wire logic PERIOD_START_I,
  input wire logic FAULT_INPUT_PIN_N_I,
  input wire logic COMPARATOR_ONE_OUTPUT_I,
  output logic PRIMARY_PWM_PIN_O,
  output logic PRIMARY_PWM_PIN_OE_N_O,
  output logic SECONDARY_PWM_PIN_O,
  output logic SECONDARY_PWM_PIN_OE_N_O
);

  //--------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------

  typedef struct packed {
    logic [7:0] unit_control;
    logic [2:0] src_sel;
    logic [1:0] sd_a;
    logic [1:0] sd_b;
    logic status;
    logic restart_en;
    logic [DB_W-1:0] db_cnt;
    logic steer_sync;
    logic [1:0] steer_req;
    logic [1:0] steer_eff;
    logic hold;
    logic run;
    logic [DIV_W-1:0] div;
    logic [31:0] rdata;
    logic slverr;
  } epwmo_st_t;

  epwmo_st_t s_q;
  epwmo_st_t s_d;

  logic wr_acc;
  logic rd_setup;
  logic fault_act;
  logic src_act;
  logic shut;
  logic tick;
  logic pwm_mode;
  logic half;
  logic single;
  logic [1:0] req;
  logic [1:0] en;
  logic [1:0] low;
  logic [1:0] act;
  logic [1:0] pin;
  logic [1:0] oe_n;
  logic [1:0] sd_state [2];
  // firmware shutdown request seen this cycle
  logic fw_set;

  //--------------------------------------------------------------------
  // shutdown sources
  //--------------------------------------------------------------------

  assign fault_act = !FAULT_INPUT_PIN_N_I;

  // codes 4 to 7 select no hardware source, like code 0
  always_comb begin
    case (s_q.src_sel)
      EPWMO_SRC_FAULT: src_act = fault_act;
      EPWMO_SRC_CMP: src_act = COMPARATOR_ONE_OUTPUT_I;
      EPWMO_SRC_BOTH: src_act = fault_act || COMPARATOR_ONE_OUTPUT_I;
      default: src_act = 1'b0;
    endcase
  end

  // source level forces pins directly
  assign shut = s_q.hold || s_q.status || src_act;

  //--------------------------------------------------------------------
  // mode decode
  //--------------------------------------------------------------------

  assign tick = (s_q.div == DIV_LAST);
  assign pwm_mode = (s_q.unit_control[3:2] == MODE_PWM);
  assign half = pwm_mode && s_q.run &&
                (s_q.unit_control[CFG_LSB +: 2] == CFG_HALF);
  assign single = pwm_mode && s_q.run &&
                  (s_q.unit_control[CFG_LSB +: 2] == CFG_SINGLE);

  // primary follows pwm; secondary is its complement in half-bridge
  assign req[0] = half ? PWM_RAW_I
                       : (single && s_q.steer_eff[0] && PWM_RAW_I);
  assign req[1] = half ? !PWM_RAW_I
                       : (single && s_q.steer_eff[1] && PWM_RAW_I);
  assign en[0] = half || (single && s_q.steer_eff[0]);
  assign en[1] = half || (single && s_q.steer_eff[1]);

  // bit 1 makes the primary active low, bit 0 the secondary
  assign low[0] = s_q.unit_control[1];
  assign low[1] = s_q.unit_control[0];
  assign sd_state[0] = s_q.sd_a;
  assign sd_state[1] = s_q.sd_b;

  //--------------------------------------------------------------------
  // apb decode
  //--------------------------------------------------------------------

  // refused accesses still complete; only pslverr tells the master
  // zero wait states: every access completes on its first access cycle
  assign PREADY_O = 1'b1;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;

  //--------------------------------------------------------------------
  // next state
  //--------------------------------------------------------------------

  always_comb begin
    s_d = s_q;
    fw_set = 1'b0;
    s_d.div = s_q.div + 1'b1;

    // register writes
    if (wr_acc) begin
      case (PADDR_I)
        UNIT_CTRL_OFS: begin
          s_d.unit_control = PWDATA_I[7:0];
        end
        AS_CTRL_OFS: begin
          s_d.src_sel = PWDATA_I[SRC_LSB +: 3];
          s_d.sd_a = PWDATA_I[SDA_LSB +: 2];
          s_d.sd_b = PWDATA_I[SDB_LSB +: 2];
          if (!src_act) begin
            s_d.status = PWDATA_I[STAT_BIT];
            if (PWDATA_I[STAT_BIT]) begin
              fw_set = 1'b1;
            end
          end
        end
        DB_CTRL_OFS: begin
          s_d.restart_en = PWDATA_I[RESTART_BIT];
          s_d.db_cnt = PWDATA_I[DB_W-1:0];
        end
        STEER_CTRL_OFS: begin
          s_d.steer_sync = PWDATA_I[SYNC_BIT];
          s_d.steer_req = PWDATA_I[1:0];
          if (!PWDATA_I[SYNC_BIT]) begin
            s_d.steer_eff = PWDATA_I[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // steering applied at period start when synchronised
    if (s_q.steer_sync && PERIOD_START_I) begin
      s_d.steer_eff = s_q.steer_req;
    end

    // auto restart tracks hardware sources only; firmware set drops at once
    if (s_q.restart_en && !src_act) begin
      s_d.status = 1'b0;
    end

    // a live source wins over any clear in the same cycle
    if (src_act) begin
      s_d.status = 1'b1;
    end

    // outputs stay forced until a period start finds everything clear;
    // a firmware set in the same cycle as a period start still holds
    if (src_act || s_q.status || fw_set) begin
      s_d.hold = 1'b1;
    end else if (PERIOD_START_I) begin
      s_d.hold = 1'b0;
    end

    // first period after enable is skipped to avoid a partial pulse
    if (!pwm_mode) begin
      s_d.run = 1'b0;
    end else if (PERIOD_START_I) begin
      s_d.run = 1'b1;
    end

    // read data captured in the setup cycle
    if (rd_setup) begin
      s_d.slverr = 1'b0;
      s_d.rdata = '0;
      case (PADDR_I)
        UNIT_CTRL_OFS: begin
          s_d.rdata[7:0] = s_q.unit_control;
        end
        AS_CTRL_OFS: begin
          s_d.rdata[STAT_BIT] = s_q.status;
          s_d.rdata[SRC_LSB +: 3] = s_q.src_sel;
          s_d.rdata[SDA_LSB +: 2] = s_q.sd_a;
          s_d.rdata[SDB_LSB +: 2] = s_q.sd_b;
        end
        DB_CTRL_OFS: begin
          s_d.rdata[RESTART_BIT] = s_q.restart_en;
          s_d.rdata[DB_W-1:0] = s_q.db_cnt;
        end
        STEER_CTRL_OFS: begin
          s_d.rdata[SYNC_BIT] = s_q.steer_sync;
          s_d.rdata[1:0] = s_q.steer_req;
        end
        PIN_STAT_OFS: begin
          s_d.rdata[1:0] = pin;
          s_d.rdata[3:2] = ~oe_n;
          s_d.rdata[4] = shut;
          s_d.rdata[5] = src_act;
          s_d.rdata[7:6] = s_q.steer_eff;
        end
        default: begin
          s_d.slverr = 1'b1;
        end
      endcase
    end else if (PSEL_I && !PENABLE_I) begin
      s_d.rdata = '0;
      s_d.slverr = !(PADDR_I == UNIT_CTRL_OFS || PADDR_I == AS_CTRL_OFS ||
                     PADDR_I == DB_CTRL_OFS || PADDR_I == STEER_CTRL_OFS);
    end
  end

  //--------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------

  // reset leaves every pin released until software enables a mode
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_q <= '0;
      s_q.unit_control <= UNIT_CTRL_RST;
      s_q.src_sel <= AS_CTRL_RST[SRC_LSB +: 3];
      s_q.sd_a <= AS_CTRL_RST[SDA_LSB +: 2];
      s_q.sd_b <= AS_CTRL_RST[SDB_LSB +: 2];
      s_q.restart_en <= DB_CTRL_RST[RESTART_BIT];
      s_q.db_cnt <= DB_CTRL_RST[DB_W-1:0];
      s_q.steer_req <= STEER_RST;
      s_q.steer_eff <= STEER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  //--------------------------------------------------------------------
  // per-pin dead band and drive
  //--------------------------------------------------------------------

  // one dead band per pin; the count is shared, the request differs
  for (genvar i = 0; i < 2; i++) begin : g_pin
    epwmo_deadband #(
      .CNT_W(DB_W)
    ) u_db (
      .clk_i(MCLK_I),
      .rst_n_i(ARST_N_I),
      .tick_i(tick),
      .bypass_i(!half),
      .req_i(req[i]),
      .count_i(s_q.db_cnt),
      .act_o(act[i])
    );

    epwmo_pin_drive u_drv (
      .clk_i(MCLK_I),
      .rst_n_i(ARST_N_I),
      .en_i(en[i]),
      .act_i(act[i]),
      .low_i(low[i]),
      .shut_i(shut),
      .state_i(sd_state[i]),
      .pin_o(pin[i]),
      .oe_n_o(oe_n[i])
    );
  end

  //--------------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------------

  // pin direction bits stay outside; oe low only claims the pad
  assign PRIMARY_PWM_PIN_O = pin[0];
  assign PRIMARY_PWM_PIN_OE_N_O = oe_n[0];
  assign SECONDARY_PWM_PIN_O = pin[1];
  assign SECONDARY_PWM_PIN_OE_N_O = oe_n[1];
  assign PRDATA_O = s_q.rdata;
  assign PSLVERR_O = s_q.slverr;

endmodule

`default_nettype wire

// >>> tb/epwmo_top_chk.sv
// port-level assertions for the pwm output stage
`default_nettype none

module epwmo_top_chk
  import epwmo_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic PWM_RAW_I,
  input wire logic PERIOD_START_I,
  input wire logic FAULT_INPUT_PIN_N_I,
  input wire logic COMPARATOR_ONE_OUTPUT_I,
  input wire logic PRIMARY_PWM_PIN_O,
  input wire logic PRIMARY_PWM_PIN_OE_N_O,
  input wire logic SECONDARY_PWM_PIN_O,
  input wire logic SECONDARY_PWM_PIN_OE_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // shadow of written bytes; hardware status changes are not tracked, so
  // half_ok stays conservative
  logic [7:0] ctl_q, asc_q;
  logic src_on, half_ok, setup, mapped;
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctl_q <= 8'h00;
      asc_q <= 8'h00;
    end else if (PSEL_I && PENABLE_I && PWRITE_I && PREADY_O) begin
      if (PADDR_I == UNIT_CTRL_OFS) ctl_q <= PWDATA_I[7:0];
      if (PADDR_I == AS_CTRL_OFS) asc_q <= PWDATA_I[7:0];
    end
  end
  assign src_on = !asc_q[6] && ((!FAULT_INPUT_PIN_N_I && asc_q[4])
    || (COMPARATOR_ONE_OUTPUT_I && asc_q[5]));
  assign half_ok = ctl_q[7:6] == CFG_HALF && ctl_q[3:0] == 4'hC && asc_q == 8'h00;
  assign setup = PSEL_I && !PENABLE_I;
  assign mapped = PADDR_I[1:0] == 2'h0 && PADDR_I <= PIN_STAT_OFS;

  default clocking dcb @(posedge MCLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  a_ready_high: assert property (PREADY_O)
    else $error("pready low");
  a_bad_addr: assert property (setup && !mapped |=> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("unmapped access not refused");
  a_force_a_hiz: assert property (src_on && asc_q[3] |-> PRIMARY_PWM_PIN_OE_N_O)
    else $error("primary not released");
  a_force_a_lvl: assert property (src_on && !asc_q[3] && !PRIMARY_PWM_PIN_OE_N_O |->
    PRIMARY_PWM_PIN_O == asc_q[2]) else $error("primary not forced");
  a_force_b_hiz: assert property (src_on && asc_q[1] |-> SECONDARY_PWM_PIN_OE_N_O)
    else $error("secondary not released");
  a_force_b_lvl: assert property (src_on && !asc_q[1] && !SECONDARY_PWM_PIN_OE_N_O |->
    SECONDARY_PWM_PIN_O == asc_q[0]) else $error("secondary not forced");
  a_no_overlap: assert property (half_ok && !PRIMARY_PWM_PIN_OE_N_O
    |-> !(PRIMARY_PWM_PIN_O && SECONDARY_PWM_PIN_O)) else $error("both pins active");
  a_off_fast: assert property ($rose(PWM_RAW_I) && half_ok && !SECONDARY_PWM_PIN_OE_N_O
    |-> ##2 !SECONDARY_PWM_PIN_O) else $error("secondary turn-off delayed");

  c_fault: cover property (src_on && !PRIMARY_PWM_PIN_OE_N_O);
  c_hiz: cover property (src_on && asc_q[3]);
  c_bad: cover property (setup && !mapped);
endmodule

bind epwmo_top epwmo_top_chk epwmo_top_chk_i (
  .MCLK_I, .ARST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O,
  .PREADY_O, .PSLVERR_O, .PWM_RAW_I, .PERIOD_START_I, .FAULT_INPUT_PIN_N_I,
  .COMPARATOR_ONE_OUTPUT_I, .PRIMARY_PWM_PIN_O, .PRIMARY_PWM_PIN_OE_N_O,
  .SECONDARY_PWM_PIN_O, .SECONDARY_PWM_PIN_OE_N_O
);

`default_nettype wire

// >>> tb/epwmo_bridge_model.sv
// bridge driver model: pull-downs on released pins, fault line
`default_nettype none

module epwmo_bridge_model (
  input wire logic pri_i,
  input wire logic pri_oe_n_i,
  input wire logic sec_i,
  input wire logic sec_oe_n_i,
  input wire logic trip_i,
  output logic fault_n_o,
  output logic hi_side_o,
  output logic lo_side_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a gate follows its pin only while driven; else the pull-down keeps it off
  assign hi_side_o = !pri_oe_n_i && pri_i;
  assign lo_side_o = !sec_oe_n_i && sec_i;
  assign fault_n_o = !trip_i;
endmodule

`default_nettype wire

// >>> tb/test_epwmo_top.sv
// self-checking bench for the pwm output stage
`default_nettype none

module test_epwmo_top
  import epwmo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic raw = 1'b0;
  logic pst = 1'b0;
  logic cmp = 1'b0;
  logic trip = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, pa, pa_oe_n, pb, pb_oe_n, flt_n, hi_side, lo_side;
  int error_cnt = 0;
  int checked = 0;
  always #5 clk = ~clk;
  epwmo_top epwmo_top_i (
    .MCLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PWM_RAW_I(raw), .PERIOD_START_I(pst), .FAULT_INPUT_PIN_N_I(flt_n),
    .COMPARATOR_ONE_OUTPUT_I(cmp), .PRIMARY_PWM_PIN_O(pa), .PRIMARY_PWM_PIN_OE_N_O(pa_oe_n),
    .SECONDARY_PWM_PIN_O(pb), .SECONDARY_PWM_PIN_OE_N_O(pb_oe_n)
  );
  epwmo_bridge_model epwmo_bridge_model_i (
    .pri_i(pa), .pri_oe_n_i(pa_oe_n), .sec_i(pb), .sec_oe_n_i(pb_oe_n), .trip_i(trip),
    .fault_n_o(flt_n), .hi_side_o(hi_side), .lo_side_o(lo_side)
  );
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("rdata", rd, e);
  endtask
  // outputs come back only after a period start, so every restart goes here
  task automatic resume();
    @(posedge clk);
    pst <= 1'b1;
    @(posedge clk);
    pst <= 1'b0;
    cyc(4);
    @(negedge clk);
  endtask
  task automatic lag(output int n);
    @(posedge clk);
    raw <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pa !== 1'b1 && n < 40);
  endtask
  task automatic t_regs();
    rdc(UNIT_CTRL_OFS, 32'h0);
    rdc(AS_CTRL_OFS, 32'h0);
    rdc(STEER_CTRL_OFS, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk("bad rd", rd, 32'h0);
    chk("bad err", err, 1);
    apb(1'b1, PIN_STAT_OFS, 32'hFF);
    chk("ro err", err, 1);
    apb(1'b1, DB_CTRL_OFS, 32'hFF);
    rdc(DB_CTRL_OFS, 32'hFF);
  endtask
  task automatic t_half();
    int n;
    logic seen;
    apb(1'b1, DB_CTRL_OFS, 32'h0);
    apb(1'b1, UNIT_CTRL_OFS, 32'h8C);
    resume();
    lag(n);
    chk("lag0", n, 3);
    chk("comp", pb, 0);
    @(posedge clk);
    raw <= 1'b0;
    apb(1'b1, DB_CTRL_OFS, 32'h03);
    cyc(30);
    lag(n);
    chk("lag3", n >= 15 && n <= 19, 1);
    @(posedge clk);
    raw <= 1'b0;
    cyc(30);
    raw <= 1'b1;
    cyc(6);
    raw <= 1'b0;
    seen = 1'b0;
    repeat (30) begin
      @(negedge clk);
      seen |= pa;
    end
    chk("short", seen, 0);
    apb(1'b1, UNIT_CTRL_OFS, 32'h0C);
  endtask
  task automatic t_shut();
    apb(1'b1, AS_CTRL_OFS, 32'h15);
    resume();
    @(posedge clk);
    trip <= 1'b1;
    @(negedge clk);
    chk("force", {pa_oe_n, hi_side, pb_oe_n}, 3'b011);
    rdc(AS_CTRL_OFS, 32'h95);
    apb(1'b1, AS_CTRL_OFS, 32'h15);
    rdc(AS_CTRL_OFS, 32'h95);
    trip <= 1'b0;
    cyc(4);
    rdc(AS_CTRL_OFS, 32'h95);
    apb(1'b1, AS_CTRL_OFS, 32'h15);
    rdc(AS_CTRL_OFS, 32'h15);
    @(negedge clk);
    chk("held", hi_side, 1);
    resume();
    chk("run", hi_side, 0);
  endtask
  task automatic t_auto();
    apb(1'b1, DB_CTRL_OFS, 32'h80);
    @(posedge clk);
    trip <= 1'b1;
    rdc(AS_CTRL_OFS, 32'h95);
    trip <= 1'b0;
    cyc(4);
    rdc(AS_CTRL_OFS, 32'h15);
    resume();
    chk("auto", hi_side, 0);
    apb(1'b1, AS_CTRL_OFS, 32'h95);
    @(negedge clk);
    chk("fw", hi_side, 1);
    rdc(AS_CTRL_OFS, 32'h15);
    resume();
    chk("fwrun", hi_side, 0);
  endtask
  task automatic t_src();
    for (int s = 0; s < 5; s++) begin
      for (int k = 0; k < 2; k++) begin
        apb(1'b1, AS_CTRL_OFS, {24'h0, 1'b0, s[2:0], 4'h9});
        if (k == 1) cmp <= 1'b1;
        else trip <= 1'b1;
        @(negedge clk);
        chk("src", pa_oe_n, s[k]);
        @(posedge clk);
        cmp <= 1'b0;
        trip <= 1'b0;
        cyc(3);
        resume();
      end
    end
  endtask
  task automatic t_steer();
    apb(1'b1, AS_CTRL_OFS, 32'h0);
    apb(1'b1, UNIT_CTRL_OFS, 32'h0D);
    apb(1'b1, STEER_CTRL_OFS, 32'h03);
    cyc(3);
    @(negedge clk);
    chk("idle", {pa_oe_n, hi_side, pb_oe_n, pb}, 4'b0001);
    @(posedge clk);
    raw <= 1'b1;
    cyc(3);
    @(negedge clk);
    chk("act", {pa_oe_n, hi_side, pb_oe_n, lo_side}, 4'b0100);
    apb(1'b1, STEER_CTRL_OFS, 32'h11);
    cyc(3);
    @(negedge clk);
    chk("sync", pb_oe_n, 0);
    resume();
    chk("synced", pb_oe_n, 1);
    apb(1'b1, STEER_CTRL_OFS, 32'h02);
    cyc(3);
    @(negedge clk);
    chk("now", {pa_oe_n, pb_oe_n}, 2'b10);
    rdc(PIN_STAT_OFS, 32'h88);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("rst", {pa_oe_n, pb_oe_n}, 2'b11);
    t_regs();
    t_half();
    t_shut();
    t_auto();
    t_src();
    t_steer();
    complete_run();
  end
  // the whole run is a few hundred cycles; this bound only cuts a hang
  initial begin
    #100us;
    error_cnt++;
    complete_run();
  end
endmodule

`default_nettype wire
